//--- include/mswd_consts.vh
// Purpose: constants for the multiply / subtract-borrow / swap datapath
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   register offsets are byte addresses on the apb slave
`ifndef MSWD_CONSTS_VH
`define MSWD_CONSTS_VH
// opcode fields, instr[15:10]
`define MSWD_OP_MUL      6'h00
`define MSWD_OP_MUL_SUB  1'h1 // instr[9]; instr[8] is the access bit
`define MSWD_OP_SUBB     6'h16
`define MSWD_OP_SWAP     6'h0e
`define MSWD_BIT_D       9
`define MSWD_BIT_A       8
// indexed literal offset window limit
`define MSWD_IDX_LIMIT   8'h5f
// access bank split: low part maps to bank 0, upper part to bank f
`define MSWD_ACC_SPLIT   8'h80
// status flag positions
`define MSWD_ST_C        0
`define MSWD_ST_DC       1
`define MSWD_ST_Z        2
`define MSWD_ST_OV       3
`define MSWD_ST_N        4
// apb register offsets
`define MSWD_REG_INSTR   12'h000
`define MSWD_REG_WORK    12'h004
`define MSWD_REG_STATUS  12'h008
`define MSWD_REG_BANK    12'h00c
`define MSWD_REG_PROD    12'h010
`define MSWD_REG_CTRL    12'h014
`define MSWD_REG_FADDR   12'h018
`define MSWD_REG_FDATA   12'h01c
`define MSWD_REG_INDEX   12'h020
// reset values
`define MSWD_RST_BYTE    8'h00
`define MSWD_RST_BANK    4'h0
`endif

//--- rtl/mswd_alu.v
// Purpose: combinational arithmetic of the three instructions
// Assumes: operands already fetched
// Notes:   pure logic, no state
`default_nettype none
`include "mswd_consts.vh"
module mswd_alu (
    input  wire [7:0]  w_in,
    input  wire [7:0]  f_in,
    input  wire        carry_in,
    output wire [15:0] product_out,
    output wire [7:0]  diff_out,
    output wire [4:0]  flags_out,
    output wire [7:0]  swap_out
);
    wire [8:0] full_sum;
    wire [4:0] low_sum;
    wire [7:0] w_inv;

    // unsigned 8x8 product, no flags derive from it
    assign product_out = {8'h00, w_in} * {8'h00, f_in}; // RULE1
    // f - w - !c done as f + ~w + c, so carry means no borrow
    assign w_inv    = ~w_in;
    assign full_sum = {1'b0, f_in} + {1'b0, w_inv} + {8'h00, carry_in}; // RULE6
    assign low_sum  = {1'b0, f_in[3:0]} + {1'b0, w_inv[3:0]}
                    + {4'h0, carry_in};
    assign diff_out = full_sum[7:0];
    assign flags_out[`MSWD_ST_C]  = full_sum[8];
    assign flags_out[`MSWD_ST_DC] = low_sum[4];
    assign flags_out[`MSWD_ST_Z]  = (full_sum[7:0] == 8'h00);
    assign flags_out[`MSWD_ST_OV] = (f_in[7] ^ w_in[7])
                                  & (f_in[7] ^ full_sum[7]);
    assign flags_out[`MSWD_ST_N]  = full_sum[7];
    // nibble exchange
    assign swap_out = {f_in[3:0], f_in[7:4]}; // RULE8
endmodule
`default_nettype wire

//--- rtl/mswd_core.v
// Purpose: datapath slice running multiply, subtract-with-borrow, swap
// Assumes: apb master obeys apb protocol; file memory is 256 bytes here
// Notes:   writing the instruction register executes it in one cycle
//
// Behaviour
// RULE1 - multiply forms the unsigned 16-bit product of w and f into the pair.
// RULE2 - the high byte holds the product's top byte; w and f stay unchanged.
// RULE3 - multiply leaves all status flags as they were.
// RULE4 - access bit 0 uses the access bank, 1 uses the bank select register.
// RULE5 - access bit 0 with extended set on and f <= 95 uses indexed offset.
// RULE6 - subtract-borrow computes f - w - !c and updates n, ov, c, dc, z.
// RULE7 - subtract-borrow writes w when d is 0 and the file register when 1.
// RULE8 - swap exchanges nibbles of f, writes per d, and touches no flag.
// RULE9 - each instruction is one word and completes in one cycle.
`default_nettype none
`include "mswd_consts.vh"
module mswd_core (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out
);
    reg  [7:0]  work;
    reg  [4:0]  status;
    reg  [3:0]  bank_select_register;
    reg  [7:0]  product_high_byte;
    reg  [7:0]  product_low_byte;
    reg         ext_enable;
    reg  [7:0]  index_base;
    reg  [7:0]  host_faddr;
    reg  [7:0]  file_mem [0:255];
    reg  [15:0] last_instr;
    reg  [11:0] next_addr;
    reg  [31:0] next_rdata;
    reg         next_err;
    reg  [7:0]  next_faddr_idx;
    wire [15:0] instr;
    wire        is_mul;
    wire        is_subb;
    wire        is_swap;
    wire        dest_file;
    wire        acc_bit;
    wire [7:0]  f_val;
    wire [15:0] prod;
    wire [7:0]  diff;
    wire [4:0]  sub_flags;
    wire [7:0]  swapped;
    wire        setup;
    wire        wr_now;
    wire        exec;
    integer     i;

    // 12-bit effective address, folded to the 256-byte file store
    function [7:0] mswd_fold;
        input [11:0] addr;
        begin
            mswd_fold = addr[7:0] ^ {addr[11:8], 4'h0};
        end
    endfunction

    assign setup   = psel_in & ~penable_in;
    assign wr_now  = psel_in & penable_in & pwrite_in & pready_out;
    assign exec    = wr_now & (paddr_in == `MSWD_REG_INSTR);
    assign instr   = pwdata_in[15:0];
    assign is_mul  = (instr[15:10] == `MSWD_OP_MUL)
                   & (instr[9] == `MSWD_OP_MUL_SUB); // both access modes
    assign is_subb = (instr[15:10] == `MSWD_OP_SUBB);
    assign is_swap = (instr[15:10] == `MSWD_OP_SWAP);
    assign dest_file = instr[`MSWD_BIT_D];
    assign acc_bit   = instr[`MSWD_BIT_A];

    // operand address selection
    always @* begin
        if (acc_bit) begin
            next_addr = {bank_select_register, instr[7:0]}; // RULE4
        end else if (ext_enable && instr[7:0] <= `MSWD_IDX_LIMIT) begin
            next_addr = {4'h0, index_base + instr[7:0]}; // RULE5
        end else if (instr[7:0] < `MSWD_ACC_SPLIT) begin
            next_addr = {4'h0, instr[7:0]}; // RULE4
        end else begin
            next_addr = {4'hf, instr[7:0]};
        end
        next_faddr_idx = mswd_fold(next_addr);
    end

    assign f_val = file_mem[next_faddr_idx];

    mswd_alu u_alu (
        .w_in        (work),
        .f_in        (f_val),
        .carry_in    (status[`MSWD_ST_C]),
        .product_out (prod),
        .diff_out    (diff),
        .flags_out   (sub_flags),
        .swap_out    (swapped)
    );

    // execution and register writes; one apb write runs one instruction
    always @(posedge clk_in) begin
        if (rst_in) begin
            work                 <= `MSWD_RST_BYTE;
            status               <= 5'h00;
            bank_select_register <= `MSWD_RST_BANK;
            product_high_byte    <= `MSWD_RST_BYTE;
            product_low_byte     <= `MSWD_RST_BYTE;
            ext_enable           <= 1'b0;
            index_base           <= `MSWD_RST_BYTE;
            host_faddr           <= `MSWD_RST_BYTE;
            last_instr           <= 16'h0000;
            for (i = 0; i < 256; i = i + 1) begin
                file_mem[i] <= `MSWD_RST_BYTE;
            end
        end else if (exec) begin
            last_instr <= instr; // RULE9
            if (is_mul) begin
                // w, f and status left alone
                product_high_byte <= prod[15:8]; // RULE2 RULE3
                product_low_byte  <= prod[7:0]; // RULE1
            end else if (is_subb) begin
                status <= sub_flags; // RULE6
                if (dest_file) begin
                    file_mem[next_faddr_idx] <= diff; // RULE7
                end else begin
                    work <= diff; // RULE7
                end
            end else if (is_swap) begin
                if (dest_file) begin
                    file_mem[next_faddr_idx] <= swapped; // RULE8
                end else begin
                    work <= swapped; // RULE8
                end
            end
        end else if (wr_now) begin
            case (paddr_in)
                `MSWD_REG_WORK:   work <= pwdata_in[7:0];
                `MSWD_REG_STATUS: status <= pwdata_in[4:0];
                `MSWD_REG_BANK:   bank_select_register <= pwdata_in[3:0];
                `MSWD_REG_PROD: begin
                    product_high_byte <= pwdata_in[15:8];
                    product_low_byte  <= pwdata_in[7:0];
                end
                `MSWD_REG_CTRL:   ext_enable <= pwdata_in[0];
                `MSWD_REG_FADDR:  host_faddr <= pwdata_in[7:0];
                `MSWD_REG_FDATA:  file_mem[host_faddr] <= pwdata_in[7:0];
                `MSWD_REG_INDEX:  index_base <= pwdata_in[7:0];
                default: begin
                end
            endcase
        end
    end

    // read mux and decode of unmapped offsets
    always @* begin
        next_err   = 1'b0;
        next_rdata = 32'h0000_0000;
        case (paddr_in)
            `MSWD_REG_INSTR:  next_rdata = {16'h0000, last_instr};
            `MSWD_REG_WORK:   next_rdata = {24'h000000, work};
            `MSWD_REG_STATUS: next_rdata = {27'h0000000, status};
            `MSWD_REG_BANK:   next_rdata = {28'h0000000,
                                            bank_select_register};
            `MSWD_REG_PROD:   next_rdata = {16'h0000, product_high_byte,
                                            product_low_byte};
            `MSWD_REG_CTRL:   next_rdata = {31'h00000000, ext_enable};
            `MSWD_REG_FADDR:  next_rdata = {24'h000000, host_faddr};
            `MSWD_REG_FDATA:  next_rdata = {24'h000000,
                                            file_mem[host_faddr]};
            `MSWD_REG_INDEX:  next_rdata = {24'h000000, index_base};
            default:          next_err   = 1'b1;
        endcase
    end

    // no wait state: ready rises in the first access cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup & next_err;
            if (setup && !pwrite_in) begin
                prdata_out <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/mswd_core_monitor.sv
// Purpose: apb answer timing and error checks on the datapath core
// Assumes: one answer in the cycle after each setup cycle
// Notes:   sees only the core's ports, bound to every instance
`default_nettype none
`include "mswd_consts.vh"
module mswd_core_monitor (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // decoded phases, shared by the checks below
    wire setup = psel_in && !penable_in;
    wire rd_ok = pready_out && !pwrite_in;
    wire mapped = paddr_in <= `MSWD_REG_INDEX && paddr_in[1:0] == 2'h0;
    chk_answer_next: assert property (setup |=> pready_out)
        else $error("no answer after setup");
    chk_ready_access: assert property (
        pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    chk_ready_single: assert property (pready_out |=> !pready_out)
        else $error("ready longer than a cycle");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_err_mapped: assert property (
        pready_out && mapped |-> !pslverr_out)
        else $error("error on mapped offset");
    chk_err_unmap: assert property (
        pready_out && !mapped |-> pslverr_out)
        else $error("unmapped offset accepted");
    chk_bad_read_zero: assert property (
        rd_ok && !mapped |-> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_status_width: assert property (
        rd_ok && paddr_in == `MSWD_REG_STATUS
        |-> prdata_out[31:5] == 27'h0)
        else $error("status upper bits set");
    chk_prod_width: assert property (
        rd_ok && paddr_in == `MSWD_REG_PROD
        |-> prdata_out[31:16] == 16'h0)
        else $error("product upper bits set");
    cov_write: cover property (pready_out && pwrite_in);
    cov_read: cover property (rd_ok && mapped);
    cov_error: cover property (pslverr_out);
    cov_exec: cover property (pready_out && pwrite_in
        && paddr_in == `MSWD_REG_INSTR);
endmodule
bind mswd_core mswd_core_monitor i_mon (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

//--- tb/mswd_core_tb.sv
// Purpose: self-checking bench running each instruction over apb
// Assumes: file addresses handed to run are already folded
// Notes:   the one-cycle gap between accesses costs time, not coverage
`default_nettype none
`include "mswd_consts.vh"
module mswd_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prd;
    wire         prdy;
    wire         perr;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    mswd_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr));
    initial forever #4 clk_in = ~clk_in;
    // hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do @(posedge clk_in); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // load f, w and status, execute, then compare all three
    task automatic run(input logic [7:0] fa, fv, w, st,
                       input logic [15:0] ins, input logic [7:0] ew, ef, es);
        xfer(1'b1, `MSWD_REG_FADDR, {24'h0, fa});
        xfer(1'b1, `MSWD_REG_FDATA, {24'h0, fv});
        xfer(1'b1, `MSWD_REG_WORK, {24'h0, w});
        xfer(1'b1, `MSWD_REG_STATUS, {24'h0, st});
        xfer(1'b1, `MSWD_REG_INSTR, {16'h0, ins});
        rd_chk(`MSWD_REG_WORK, {24'h0, ew});
        rd_chk(`MSWD_REG_FDATA, {24'h0, ef});
        rd_chk(`MSWD_REG_STATUS, {24'h0, es});
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(`MSWD_REG_PROD, 32'h0);
        rd_chk(`MSWD_REG_STATUS, 32'h0);
        xfer(1'b1, `MSWD_REG_BANK, 32'h2);
        run(8'h30, 8'hb5, 8'hc4, 8'h15, 16'h0310, 8'hc4, 8'hb5, 8'h15);
        rd_chk(`MSWD_REG_PROD, 32'h8a94);
        // zero product with every flag but z set: z must stay clear
        run(8'h10, 8'h00, 8'h7f, 8'h1b, 16'h0210, 8'h7f, 8'h00, 8'h1b);
        rd_chk(`MSWD_REG_PROD, 32'h0);
        $display("multiply test done");
        run(8'h10, 8'h19, 8'h0d, 8'h01, 16'h5a10, 8'h0d, 8'h0c, 8'h01);
        run(8'h10, 8'h1b, 8'h1a, 8'h00, 16'h5810, 8'h00, 8'h1b, 8'h07);
        run(8'h10, 8'h03, 8'h0e, 8'h01, 16'h5a10, 8'h0e, 8'hf5, 8'h10);
        run(8'h10, 8'h80, 8'h01, 8'h01, 16'h5a10, 8'h01, 8'h7f, 8'h09);
        $display("subtract test done");
        run(8'h10, 8'h53, 8'h00, 8'h1f, 16'h3a10, 8'h00, 8'h35, 8'h1f);
        run(8'h10, 8'h53, 8'h00, 8'h00, 16'h3810, 8'h35, 8'h53, 8'h00);
        $display("swap test done");
        xfer(1'b1, `MSWD_REG_CTRL, 32'h1);
        xfer(1'b1, `MSWD_REG_INDEX, 32'h40);
        run(8'h9f, 8'h21, 8'h00, 8'h00, 16'h385f, 8'h12, 8'h21, 8'h00);
        run(8'h60, 8'h9a, 8'h00, 8'h00, 16'h3860, 8'ha9, 8'h9a, 8'h00);
        run(8'h60, 8'h9a, 8'h00, 8'h00, 16'h3890, 8'ha9, 8'h9a, 8'h00);
        // access bit 1 beats the indexed window: bank 2, f 5f folds to 7f
        run(8'h7f, 8'hc3, 8'h00, 8'h00, 16'h395f, 8'h3c, 8'hc3, 8'h00);
        rd_chk(`MSWD_REG_INSTR, 32'h395f);
        // an undecoded opcode must leave w, f and status alone
        run(8'h7f, 8'hc3, 8'h5a, 8'h1f, 16'h1c7f, 8'h5a, 8'hc3, 8'h1f);
        $display("addressing test done");
        rd_chk(12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("unmapped test done");
        give_verdict();
    end
endmodule
`default_nettype wire
